// ---- adcs_regs.svh ----
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADCS_OFF_CTRL     2'h0
`define ADCS_OFF_CFG      2'h1
`define ADCS_OFF_RES_HIGH 2'h2
`define ADCS_OFF_RES_LOW  2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCS_CTRL_START   7
`define ADCS_CTRL_BUSY    6
`define ADCS_CTRL_PWR     5
`define ADCS_CTRL_JUSTIFY 4
`define ADCS_CTRL_CHAN_HI 1
`define ADCS_CTRL_CHAN_LO 0
`define ADCS_CFG_DIV_HI   2
`define ADCS_CFG_DIV_LO   0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCS_CTRL_RST     8'h00
`define ADCS_CFG_RST      8'h00
`define ADCS_RES_RST      8'h00

// ----------------------------------------
// Timing counts, in conversion clocks
// ----------------------------------------
`define ADCS_SAMPLE_CLKS  4
`define ADCS_CONV_CLKS    12
`define ADCS_TOTAL_CLKS   (`ADCS_SAMPLE_CLKS + `ADCS_CONV_CLKS)

`endif

// ---- adcs_pkg.sv ----
`default_nettype none
package adcs_pkg;

    typedef enum logic [1:0]
    {
        ADCS_IDLE    = 2'b00,
        ADCS_SAMPLE  = 2'b01,
        ADCS_CONVERT = 2'b11
    } adcs_fsm_e;

    typedef struct packed
    {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcs_bus_req_s;

    typedef struct packed
    {
        logic       start;
        logic       pwr;
        logic       justify;
        logic [1:0] chan;
        logic [7:0] cfg;
        logic [7:0] res_high;
        logic [7:0] res_low;
        adcs_fsm_e  fsm;
        logic       busy;
        logic [6:0] div_cnt;
        logic [3:0] tick_cnt;
        logic       tick;
        logic       sample;
        logic       irq;
        logic [7:0] rdata;
    } adcs_state_s;

endpackage : adcs_pkg
`default_nettype wire

// ---- adcs_sequencer.sv ----
// Operation
// RL1 - Start only on start bit rise then fall
// RL2 - Successful start sets busy flag
// RL3 - Finished conversion clears busy flag
// RL4 - Completion raises the interrupt request flag
// RL5 - Enabled interrupt vectors on completion
// RL6 - Software may poll busy for completion
// RL7 - Conversion clock is system clock over 2^select
// RL8 - Software keeps conversion clock within 0.5-10 us
// RL9 - Converter powered only while enable bit high
// RL10 - Software waits settling before first start
// RL11 - Four sample clocks then twelve conversion clocks
// RL12 - Conversion runs on without processor help
// RL13 - Justify bit picks result byte layout
// RL14 - Disabled converter leaves result bytes unchanged
// RL15 - Results load as busy clears
// RL16 - Ignore start while busy or unpowered
`include "adcs_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module adcs_sequencer
    import adcs_pkg::*;
#(
    parameter int RES_BITS = 12
)
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst,
    // Register port
    input  wire adcs_bus_req_s bus_req,
    output var  logic [7:0]    bus_rdata,
    // Analog core
    input  wire logic [11:0]   adc_data,
    output var  logic          adc_power_on,
    output var  logic          adc_sample,
    output var  logic          adc_clk_tick,
    output var  logic [1:0]    adc_chan,
    // Status and interrupt
    output var  logic          conversion_busy_flag,
    output var  logic          adc_irq_pulse
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (RES_BITS != 12)
    begin : g_bad_width
        $error("adcs_sequencer serves only a 12-bit result");
    end

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic logic [6:0] div_last(input logic [2:0] sel);
        logic [7:0] full;
        full = 8'h01 << sel;
        return 7'(full - 8'h01);
    endfunction : div_last

    function automatic logic [15:0] fmt_result(input logic [11:0] d,
                                               input logic        just);
        if (just)
            return {4'h0, d[11:8], d[7:0]};
        else
            return {d[11:4], d[3:0], 4'h0};
    endfunction : fmt_result

    // ----------------------------------------
    // State
    // ----------------------------------------
    adcs_state_s s_reg;
    adcs_state_s s_next;
    logic        start_fall;
    logic        done;
    logic [15:0] res_fmt;

    localparam logic [3:0] SAMPLE_LAST = 4'(`ADCS_SAMPLE_CLKS - 1);
    localparam logic [3:0] TOTAL_LAST  = 4'(`ADCS_TOTAL_CLKS - 1);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        s_next       = s_reg;
        s_next.tick  = 1'b0;
        s_next.irq   = 1'b0;
        s_next.rdata = 8'h00;
        done         = 1'b0;
        res_fmt      = fmt_result(adc_data, s_reg.justify); // [RL13]

        // Only a write that drops a set start bit counts as a start
        start_fall = bus_req.wr && (bus_req.addr == `ADCS_OFF_CTRL)
                     && s_reg.start && !bus_req.wdata[`ADCS_CTRL_START]; // [RL1]

        if (bus_req.wr)
        begin
            case (bus_req.addr)
                `ADCS_OFF_CTRL:
                begin
                    s_next.start   = bus_req.wdata[`ADCS_CTRL_START];
                    s_next.pwr     = bus_req.wdata[`ADCS_CTRL_PWR];
                    s_next.justify = bus_req.wdata[`ADCS_CTRL_JUSTIFY];
                    s_next.chan    = bus_req.wdata[`ADCS_CTRL_CHAN_HI:`ADCS_CTRL_CHAN_LO];
                end
                `ADCS_OFF_CFG:
                begin
                    s_next.cfg = bus_req.wdata;
                end
                default:
                begin
                    s_next.cfg = s_reg.cfg;
                end
            endcase
        end

        if (bus_req.rd)
        begin
            case (bus_req.addr)
                `ADCS_OFF_CTRL:
                begin
                    s_next.rdata = {s_reg.start, s_reg.busy, s_reg.pwr,
                                    s_reg.justify, 2'b00, s_reg.chan}; // [RL6]
                end
                `ADCS_OFF_CFG:
                begin
                    s_next.rdata = s_reg.cfg;
                end
                `ADCS_OFF_RES_HIGH:
                begin
                    s_next.rdata = s_reg.res_high;
                end
                default:
                begin
                    s_next.rdata = s_reg.res_low;
                end
            endcase
        end

        case (s_reg.fsm)
            ADCS_IDLE:
            begin
                // A start while unpowered is dropped, not remembered
                if (start_fall && bus_req.wdata[`ADCS_CTRL_PWR] && s_reg.pwr) // [RL16]
                begin
                    s_next.fsm      = ADCS_SAMPLE;
                    s_next.busy     = 1'b1; // [RL2]
                    s_next.sample   = 1'b1;
                    s_next.div_cnt  = 7'h00;
                    s_next.tick_cnt = 4'h0;
                end
            end
            ADCS_SAMPLE, ADCS_CONVERT:
            begin
                // Runs on its own; start edges here are ignored [RL12] [RL16]
                if (!s_reg.pwr)
                begin
                    // Power loss aborts; results keep their old value [RL9] [RL14]
                    s_next.fsm    = ADCS_IDLE;
                    s_next.busy   = 1'b0;
                    s_next.sample = 1'b0;
                end
                else if (s_reg.div_cnt >= div_last(s_reg.cfg[`ADCS_CFG_DIV_HI:`ADCS_CFG_DIV_LO]))
                begin
                    // >= so a divider change mid-run cannot overrun the count [RL7]
                    s_next.div_cnt  = 7'h00;
                    s_next.tick     = 1'b1;
                    s_next.tick_cnt = s_reg.tick_cnt + 4'h1;
                    if (s_reg.tick_cnt == SAMPLE_LAST) // [RL11]
                    begin
                        s_next.fsm    = ADCS_CONVERT;
                        s_next.sample = 1'b0;
                    end
                    if (s_reg.tick_cnt == TOTAL_LAST) // [RL11]
                    begin
                        done            = 1'b1;
                        s_next.fsm      = ADCS_IDLE;
                        s_next.busy     = 1'b0; // [RL3]
                        s_next.irq      = 1'b1; // [RL4] [RL5]
                        s_next.res_high = res_fmt[15:8]; // [RL15]
                        s_next.res_low  = res_fmt[7:0]; // [RL15]
                    end
                end
                else
                begin
                    s_next.div_cnt = s_reg.div_cnt + 7'h01;
                end
            end
            default:
            begin
                s_next.fsm    = ADCS_IDLE;
                s_next.busy   = 1'b0;
                s_next.sample = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s_reg          <= '0;
            s_reg.start    <= 1'(`ADCS_CTRL_RST >> `ADCS_CTRL_START);
            s_reg.cfg      <= `ADCS_CFG_RST;
            s_reg.res_high <= `ADCS_RES_RST;
            s_reg.res_low  <= `ADCS_RES_RST;
            s_reg.fsm      <= ADCS_IDLE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign bus_rdata            = s_reg.rdata;
    assign adc_power_on         = s_reg.pwr; // [RL9]
    assign adc_sample           = s_reg.sample;
    assign adc_clk_tick         = s_reg.tick;
    assign adc_chan             = s_reg.chan;
    assign conversion_busy_flag = s_reg.busy;
    assign adc_irq_pulse        = s_reg.irq; // [RL5]

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (rst);

    property p_start_needs_fall;
        $rose(s_reg.busy) |-> $past(start_fall);
    endproperty
    a_start_needs_fall: assert property (p_start_needs_fall) // [RL1]
        else $error("busy rose without a start fall");

    property p_start_sets_busy;
        (start_fall && s_reg.pwr && bus_req.wdata[`ADCS_CTRL_PWR] && !s_reg.busy)
            |=> s_reg.busy && s_reg.sample;
    endproperty
    a_start_sets_busy: assert property (p_start_sets_busy) // [RL2]
        else $error("valid start did not set busy");

    property p_done_clears_busy;
        done |=> !s_reg.busy && s_reg.irq;
    endproperty
    a_done_clears_busy: assert property (p_done_clears_busy) // [RL3]
        else $error("busy not cleared at completion");

    property p_irq_on_fall;
        s_reg.irq |-> $fell(s_reg.busy) && $past(s_reg.pwr);
    endproperty
    a_irq_on_fall: assert property (p_irq_on_fall) // [RL4]
        else $error("interrupt pulse without completion");

    property p_irq_single;
        s_reg.irq |=> !s_reg.irq;
    endproperty
    a_irq_single: assert property (p_irq_single) // [RL5]
        else $error("interrupt pulse longer than one cycle");

    property p_div_two;
        disable iff (rst || !s_reg.pwr)
        ($rose(s_reg.busy) && s_reg.cfg[2:0] == 3'h1)
            |-> !s_reg.tick [*2] ##1 s_reg.tick ##1 !s_reg.tick ##1 s_reg.tick;
    endproperty
    a_div_two: assert property (p_div_two) // [RL7]
        else $error("divide-by-two tick spacing wrong");

    property p_power_abort;
        (!s_reg.pwr && s_reg.busy) |=> !s_reg.busy && !s_reg.irq;
    endproperty
    a_power_abort: assert property (p_power_abort) // [RL9]
        else $error("conversion survived power off");

    property p_sample_four;
        disable iff (rst || !s_reg.pwr)
        ($rose(s_reg.busy) && s_reg.cfg[2:0] == 3'h0)
            |-> s_reg.sample [*4] ##1 !s_reg.sample;
    endproperty
    a_sample_four: assert property (p_sample_four) // [RL11]
        else $error("sample phase not four clocks");

    property p_total_sixteen;
        disable iff (rst || !s_reg.pwr)
        ($rose(s_reg.busy) && s_reg.cfg[2:0] == 3'h0)
            |-> s_reg.busy [*8] ##1 s_reg.busy [*8] ##1 !s_reg.busy;
    endproperty
    a_total_sixteen: assert property (p_total_sixteen) // [RL11]
        else $error("conversion not sixteen clocks");

    property p_res_hold;
        (!s_reg.pwr && !s_reg.busy) |=> $stable(s_reg.res_high) && $stable(s_reg.res_low);
    endproperty
    a_res_hold: assert property (p_res_hold) // [RL14]
        else $error("result changed while disabled");

    property p_res_with_busy;
        $changed(s_reg.res_low) || $changed(s_reg.res_high) |-> $fell(s_reg.busy) && s_reg.irq;
    endproperty
    a_res_with_busy: assert property (p_res_with_busy) // [RL15]
        else $error("result loaded apart from busy clear");

    property p_ignore_busy;
        (start_fall && s_reg.busy) |=> s_reg.tick_cnt != 4'h0 || !s_reg.busy
                                        || $past(s_reg.tick_cnt) == TOTAL_LAST;
    endproperty
    a_ignore_busy: assert property (p_ignore_busy) // [RL16]
        else $error("start restarted a running conversion");

endmodule : adcs_sequencer
`default_nettype wire

// ---- tb_adcs_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_adcs_sequencer
    import adcs_pkg::*;
;
    typedef struct packed
    {
        logic [1:0] a;
        logic [7:0] w;
        logic [7:0] r;
        logic       p;
        logic [1:0] c;
    } adcs_tb_row_s;

    logic          sys_clk;
    logic          rst;
    adcs_bus_req_s bus_req;
    logic [7:0]    bus_rdata;
    logic [11:0]   adc_data;
    logic          adc_power_on;
    logic          adc_sample;
    logic          adc_clk_tick;
    logic [1:0]    adc_chan;
    logic          conversion_busy_flag;
    logic          adc_irq_pulse;
    int            failures;
    int            comparisons;
    int            cycles;
    logic [15:0]   n_busy;
    logic [15:0]   n_samp;
    logic [15:0]   n_tick;
    logic [15:0]   n_irq;
    logic [7:0]    d;
    logic [7:0]    keep_hi;
    logic [7:0]    keep_lo;
    adcs_tb_row_s  rows [7];

    adcs_sequencer i_dut
    (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .bus_req              (bus_req),
        .bus_rdata            (bus_rdata),
        .adc_data             (adc_data),
        .adc_power_on         (adc_power_on),
        .adc_sample           (adc_sample),
        .adc_clk_tick         (adc_clk_tick),
        .adc_chan             (adc_chan),
        .conversion_busy_flag (conversion_busy_flag),
        .adc_irq_pulse        (adc_irq_pulse)
    );

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] w);
        @(posedge sys_clk);
        bus_req.addr  <= a;
        bus_req.wdata <= w;
        bus_req.wr    <= 1'b1;
        @(posedge sys_clk);
        bus_req.wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] r);
        @(posedge sys_clk);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        @(posedge sys_clk);
        bus_req.rd   <= 1'b0;
        #1 r = bus_rdata;
    endtask : rd_reg

    // Counters are cleared off the edge so they never race the sampling process
    task automatic clr_cnt();
        #1;
        n_busy = '0;
        n_samp = '0;
        n_tick = '0;
        n_irq  = '0;
    endtask : clr_cnt

    task automatic conv(input logic [2:0] sel, input logic just, input logic [11:0] data);
        int         n;
        logic [7:0] hi;
        logic [7:0] lo;
        wr_reg(2'h1, {5'h00, sel});
        adc_data <= data;
        wr_reg(2'h0, {3'b101, just, 4'h0});
        repeat (3) @(posedge sys_clk); // Settling time after power-up
        #1 check("busy_level", 16'(conversion_busy_flag), 16'h0000);
        clr_cnt();
        wr_reg(2'h0, {3'b001, just, 4'h0});
        #1 check("busy_set", 16'(conversion_busy_flag), 16'h0001);
        rd_reg(2'h0, hi);
        check("busy_bit_set", 16'(hi[6]), 16'h0001);
        n = 0;
        while (conversion_busy_flag === 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        check("busy_clr", 16'(conversion_busy_flag), 16'h0000);
        check("irq", 16'(adc_irq_pulse), 16'h0001);
        @(posedge sys_clk);
        #1 check("busy_len", n_busy, 16'd16 << sel);
        check("sample_len", n_samp, 16'd4 << sel);
        check("ticks", n_tick, 16'd16);
        check("irq_cnt", n_irq, 16'h0001);
        rd_reg(2'h0, lo);
        check("busy_bit_clr", 16'(lo[6]), 16'h0000);
        rd_reg(2'h2, hi);
        rd_reg(2'h3, lo);
        check("res_hi", 16'(hi), just ? 16'(data[11:8]) : 16'(data[11:4]));
        check("res_lo", 16'(lo), just ? 16'(data[7:0]) : 16'({data[3:0], 4'h0}));
    endtask : conv

    // ----------------------------------------
    // Clock, counters and timeout
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        if (conversion_busy_flag === 1'b1) n_busy++;
        if (adc_sample === 1'b1) n_samp++;
        if (adc_clk_tick === 1'b1) n_tick++;
        if (adc_irq_pulse === 1'b1) n_irq++;
    end

    // Longest run is about 4650 cycles; the ceiling leaves wide margin
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        bus_req = '0;
        adc_data = '0;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        rows = '{'{2'h0, 8'h5F, 8'h13, 1'b0, 2'h3}, '{2'h0, 8'h2C, 8'h20, 1'b1, 2'h0},
                 '{2'h0, 8'h32, 8'h32, 1'b1, 2'h2}, '{2'h1, 8'hA5, 8'hA5, 1'b1, 2'h2},
                 '{2'h1, 8'h00, 8'h00, 1'b1, 2'h2}, '{2'h2, 8'hFF, 8'h00, 1'b1, 2'h2},
                 '{2'h3, 8'hFF, 8'h00, 1'b1, 2'h2}};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1 check("rst_out", {11'h000, conversion_busy_flag, adc_irq_pulse, adc_power_on,
                             adc_sample, adc_clk_tick}, 16'h0000);
        for (int a = 0; a < 4; a++)
        begin
            rd_reg(2'(a), d);
            check("rst_reg", 16'(d), 16'h0000);
        end
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].w);
            rd_reg(rows[i].a, d);
            check("reg_rd", 16'(d), 16'(rows[i].r));
            check("pwr_out", 16'(adc_power_on), 16'(rows[i].p));
            check("chan_out", 16'(adc_chan), 16'(rows[i].c));
        end
        for (int s = 0; s < 8; s++)
            conv(3'(s), s[0], 12'h3C5 + 12'(s) * 12'h1A7);
        // Start pulses arriving mid-run must neither extend nor queue a run
        wr_reg(2'h1, 8'h00);
        wr_reg(2'h0, 8'hA0);
        clr_cnt();
        wr_reg(2'h0, 8'h20);
        wr_reg(2'h0, 8'hA0);
        wr_reg(2'h0, 8'h20);
        repeat (40) @(posedge sys_clk);
        #1 check("busy_ign", n_busy, 16'd16);
        check("irq_ign", n_irq, 16'h0001);
        wr_reg(2'h0, 8'h80);
        clr_cnt();
        wr_reg(2'h0, 8'h00);
        repeat (5) @(posedge sys_clk);
        #1 check("busy_off", n_busy, 16'h0000);
        check("pwr_off", 16'(adc_power_on), 16'h0000);
        // Abort by clearing power mid-run: no result, no request
        rd_reg(2'h2, keep_hi);
        rd_reg(2'h3, keep_lo);
        wr_reg(2'h1, 8'h04); // 800 ns conversion clock stays in band
        wr_reg(2'h0, 8'hA0);
        adc_data <= 12'h9E1;
        wr_reg(2'h0, 8'h20);
        clr_cnt();
        repeat (10) @(posedge sys_clk);
        wr_reg(2'h0, 8'h00);
        repeat (300) @(posedge sys_clk);
        #1 check("abort_busy", 16'(conversion_busy_flag), 16'h0000);
        check("abort_irq", n_irq, 16'h0000);
        rd_reg(2'h2, d);
        check("keep_hi", 16'(d), 16'(keep_hi));
        rd_reg(2'h3, d);
        check("keep_lo", 16'(d), 16'(keep_lo));
        // Second reset in mid-run
        wr_reg(2'h0, 8'hA0);
        wr_reg(2'h0, 8'h20);
        repeat (5) @(posedge sys_clk);
        rst <= 1'b1;
        // Three edges in reset so sampled history is clean when checking resumes
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1 check("rst2_out", {11'h000, conversion_busy_flag, adc_irq_pulse, adc_power_on,
                              adc_sample, adc_clk_tick}, 16'h0000);
        rd_reg(2'h2, d);
        check("rst2_hi", 16'(d), 16'h0000);
        give_verdict();
    end
endmodule : tb_adcs_sequencer
`default_nettype wire
